// ===== core/enc_vbi_regs.vh
`ifndef ENC_VBI_REGS_VH
`define ENC_VBI_REGS_VH
// slave addresses (7-bit) and direction bit
`define EVB_SLAVE_ADDR_A    7'h44
`define EVB_SLAVE_ADDR_B    7'h46
`define EVB_RW_READ         1'b1
// byte framing
`define EVB_BITS_PER_BYTE   4'h8
// subaddresses
`define EVB_SUB_WSS_LOW     8'h26
`define EVB_SUB_WSS_HIGH    8'h27
`define EVB_SUB_RT_BURST    8'h28
`define EVB_SUB_BURST_END   8'h29
`define EVB_SUB_COPY0       8'h2A
`define EVB_SUB_COPY1       8'h2B
`define EVB_SUB_COPY_HIGH   8'h2C
// field positions
`define EVB_BIT_ENABLE      7
`define EVB_BIT_RT_COLOR    7
`define EVB_BIT_RT_FIELD    6
`define EVB_POS_FIELD_MSB   5
`define EVB_POS_CODE_HI_MSB 3
`define EVB_RT_ENABLE_BIT   7
// reset values
`define EVB_RST_WSS_LOW     8'h00
`define EVB_RST_WSS_HIGH    8'h00
`define EVB_RST_RT_BURST    8'h21
`define EVB_RST_BURST_END   8'h1D
`define EVB_RST_COPY0       8'h00
`define EVB_RST_COPY1       8'h00
`define EVB_RST_COPY_HIGH   8'h00
`define EVB_RST_BURST_START 6'h21
`define EVB_RST_BURST_STOP  6'h1D
// reserved-bit masks on write
`define EVB_MASK_WSS_HIGH   8'hBF
`define EVB_MASK_BURST_END  8'h3F
`define EVB_MASK_COPY_HIGH  8'h8F
`endif

// ===== core/evb_i2c_regs.v
`timescale 1ns/1ns
`include "enc_vbi_regs.vh"

// Notes on behaviour
// - start, address, subaddress, data bytes, stop
// - answer either of two slave addresses
// - address lsb zero writes, one reads
// - slave acknowledges address, subaddress, every data
// - subaddress increments after each data byte
// - 26h: enhanced services and aspect ratio
// - 27h bit7 widescreen enable, reset zero
// - 27h reserved and subtitles code fields
// - 28h bit7 honours realtime colour detect
// - 28h bit6 field sequence source select
// - 28h burst start, reset 33
// - 29h burst end, reset 29
// - 2Ah copy code bits 7..0
// - 2Ch bit7 copy output enable, reset off
// - 2Ch copy code bits 19..16
// - realtime selections act only when enabled
module evb_i2c_regs (
  input  wire        i_ref_clk,
  input  wire        i_reset_n,
  input  wire        i_scl,
  input  wire        i_sda,
  output reg         o_sda_oe,
  input  wire        i_field_start,
  input  wire        i_realtime_control_enable,
  input  wire        i_field_rate_select,
  input  wire        i_rt_field_rate,
  input  wire        i_rt_color_detect,
  output reg         o_widescreen_out_enable,
  output reg  [13:0] o_widescreen_code_bits,
  output reg         o_color_detect_active,
  output reg         o_field_sequence,
  output reg  [5:0]  o_burst_start,
  output reg  [5:0]  o_burst_end,
  output reg         o_copy_data_out_enable,
  output reg  [19:0] o_copy_gen_code
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_SUB  = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_READ = 3'h4;
  localparam ST_SKIP = 3'h5;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // a level counts only once the second and third stages agree
  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg       scl_q;
  reg       sda_q;

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], i_scl};
      sda_sync <= {sda_sync[1:0], i_sda};
      if (scl_sync[1] == scl_sync[2])
        scl_q <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_q <= sda_sync[2];
    end
  end

  // the filtered copy gives one-cycle edge events; a start or stop needs scl high
  wire scl_new = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
  wire sda_new = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
  wire scl_rise = !scl_q && scl_new;
  wire scl_fall = scl_q && !scl_new;
  wire bus_start = scl_q && scl_new && sda_q && !sda_new;
  wire bus_stop  = scl_q && scl_new && !sda_q && sda_new;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [7:0] wss_low;
  reg [7:0] wss_high;
  reg [7:0] rt_burst;
  reg [7:0] burst_end_reg;
  reg [7:0] copy0;
  reg [7:0] copy1;
  reg [7:0] copy_high;

  function [7:0] evb_read;
    input [7:0] sub;
    begin
      case (sub)
        `EVB_SUB_WSS_LOW:   evb_read = wss_low;
        `EVB_SUB_WSS_HIGH:  evb_read = wss_high;
        `EVB_SUB_RT_BURST:  evb_read = rt_burst;
        `EVB_SUB_BURST_END: evb_read = burst_end_reg;
        `EVB_SUB_COPY0:     evb_read = copy0;
        `EVB_SUB_COPY1:     evb_read = copy1;
        `EVB_SUB_COPY_HIGH: evb_read = copy_high;
        default:            evb_read = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // serial protocol engine
  // ----------------------------------------
  reg [2:0] state;
  reg [7:0] shift;
  reg [3:0] bit_cnt;
  reg [7:0] subaddr;
  reg       ack_phase;
  reg       ack_ok;
  reg       wr_pulse;
  reg [7:0] wr_data;
  reg [7:0] wr_addr;

  // ----------------------------------------
  // byte framing and read data
  // ----------------------------------------
  // the count hits the byte length once, on the eighth rise
  wire       byte_done = (bit_cnt == `EVB_BITS_PER_BYTE);
  wire       addr_hit  = (shift[7:1] == `EVB_SLAVE_ADDR_A) ||
                         (shift[7:1] == `EVB_SLAVE_ADDR_B);
  // one decode feeds the first bit and the rest of an outgoing byte
  wire [7:0] read_byte = evb_read(subaddr);

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state     <= ST_IDLE;
      shift     <= 8'h00;
      bit_cnt   <= 4'h0;
      subaddr   <= 8'h00;
      ack_phase <= 1'b0;
      ack_ok    <= 1'b0;
      o_sda_oe  <= 1'b0;
      wr_pulse  <= 1'b0;
      wr_data   <= 8'h00;
      wr_addr   <= 8'h00;
    end else begin
      // write strobe lasts a single clock
      wr_pulse <= 1'b0;
      if (bus_stop) begin
        // stop ends the frame and frees the line
        state    <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else if (bus_start) begin
        state     <= ST_ADDR;
        bit_cnt   <= 4'h0;
        ack_phase <= 1'b0;
        o_sda_oe  <= 1'b0;
      end else if (scl_rise && !ack_phase && state != ST_IDLE) begin
        // while reading, shift holds the outgoing byte
        if (state != ST_READ)
          shift <= {shift[6:0], sda_new};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_rise && ack_phase && state == ST_READ && sda_new) begin
        // master nack ends the read
        state <= ST_SKIP;
      end else if (scl_fall && state != ST_IDLE && state != ST_SKIP) begin
        if (ack_phase) begin
          // ack over: release the line or present the next read bit
          ack_phase <= 1'b0;
          bit_cnt   <= 4'h0;
          if (state == ST_READ) begin
            o_sda_oe <= !read_byte[7];
            shift    <= {read_byte[6:0], 1'b1};
          end else begin
            o_sda_oe <= 1'b0;
          end
          if (!ack_ok)
            state <= ST_SKIP;
        end else if (state == ST_READ) begin
          if (byte_done) begin
            ack_phase <= 1'b1;
            o_sda_oe  <= 1'b0;
            subaddr   <= subaddr + 8'h01;
          end else begin
            o_sda_oe <= !shift[7];
            shift    <= {shift[6:0], 1'b1};
          end
        end else if (byte_done) begin
          ack_phase <= 1'b1;
          ack_ok    <= 1'b1;
          o_sda_oe  <= 1'b1;
          case (state)
            ST_ADDR: begin
              if (addr_hit) begin
                state <= (shift[0] == `EVB_RW_READ) ? ST_READ : ST_SUB;
              end else begin
                ack_ok   <= 1'b0;
                o_sda_oe <= 1'b0;
              end
            end
            ST_SUB: begin
              subaddr <= shift;
              state   <= ST_DATA;
            end
            default: begin
              wr_pulse <= 1'b1;
              wr_data  <= shift;
              wr_addr  <= subaddr;
              subaddr  <= subaddr + 8'h01;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wss_low       <= `EVB_RST_WSS_LOW;
      wss_high      <= `EVB_RST_WSS_HIGH;
      rt_burst      <= `EVB_RST_RT_BURST;
      burst_end_reg <= `EVB_RST_BURST_END;
      copy0         <= `EVB_RST_COPY0;
      copy1         <= `EVB_RST_COPY1;
      copy_high     <= `EVB_RST_COPY_HIGH;
    end else if (wr_pulse) begin
      // reserved bits kept zero even if the host slips
      case (wr_addr)
        `EVB_SUB_WSS_LOW:   wss_low <= wr_data;
        `EVB_SUB_WSS_HIGH:  wss_high <= wr_data & `EVB_MASK_WSS_HIGH;
        `EVB_SUB_RT_BURST:  rt_burst <= wr_data;
        `EVB_SUB_BURST_END: burst_end_reg <= wr_data & `EVB_MASK_BURST_END;
        `EVB_SUB_COPY0:     copy0 <= wr_data;
        // copy code middle byte
        `EVB_SUB_COPY1:     copy1 <= wr_data;
        `EVB_SUB_COPY_HIGH: copy_high <= wr_data & `EVB_MASK_COPY_HIGH;
        // unmapped subaddress: acknowledged, byte dropped
        default:            wss_low <= wss_low;
      endcase
    end
  end

  // ----------------------------------------
  // field-aligned outputs
  // ----------------------------------------
  // realtime selections only act while the enable is high
  wire next_color_detect   = rt_burst[`EVB_BIT_RT_COLOR] && i_realtime_control_enable &&
                             i_rt_color_detect;
  wire next_field_sequence = (rt_burst[`EVB_BIT_RT_FIELD] && i_realtime_control_enable) ?
                             i_rt_field_rate : i_field_rate_select;

  // settings move to the video side only at a field start, so a line never mixes old and new
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_widescreen_out_enable <= 1'b0;
      o_widescreen_code_bits  <= 14'h0000;
      o_color_detect_active   <= 1'b0;
      o_field_sequence        <= 1'b0;
      o_burst_start           <= `EVB_RST_BURST_START;
      o_burst_end             <= `EVB_RST_BURST_STOP;
      o_copy_data_out_enable  <= 1'b0;
      o_copy_gen_code         <= 20'h00000;
    end else if (i_field_start) begin
      o_widescreen_out_enable <= wss_high[`EVB_BIT_ENABLE];
      o_widescreen_code_bits  <= {wss_high[`EVB_POS_FIELD_MSB:0], wss_low};
      o_color_detect_active   <= next_color_detect;
      o_field_sequence        <= next_field_sequence;
      o_burst_start           <= rt_burst[`EVB_POS_FIELD_MSB:0];
      o_burst_end             <= burst_end_reg[`EVB_POS_FIELD_MSB:0];
      o_copy_data_out_enable  <= copy_high[`EVB_BIT_ENABLE];
      o_copy_gen_code         <= {copy_high[`EVB_POS_CODE_HI_MSB:0], copy1, copy0};
    end
  end

endmodule // evb_i2c_regs

// ===== testbench/evb_i2c_regs_monitor.sv
`timescale 1ns/1ns
module evb_i2c_regs_monitor (
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire logic        i_scl,
  input wire logic        o_sda_oe,
  input wire logic        i_field_start,
  input wire logic        i_realtime_control_enable,
  input wire logic        i_field_rate_select,
  input wire logic        i_rt_field_rate,
  input wire logic        i_rt_color_detect,
  input wire logic        o_widescreen_out_enable,
  input wire logic [13:0] o_widescreen_code_bits,
  input wire logic        o_color_detect_active,
  input wire logic        o_field_sequence,
  input wire logic [5:0]  o_burst_start,
  input wire logic [5:0]  o_burst_end,
  input wire logic        o_copy_data_out_enable,
  input wire logic [19:0] o_copy_gen_code
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  a_out_hold: assert property (
    !i_field_start |=> $stable({o_widescreen_code_bits, o_burst_start, o_burst_end,
      o_copy_gen_code, o_widescreen_out_enable, o_copy_data_out_enable}))
    else $error("outputs moved without field start");
  a_reset_vals: assert property ($rose(i_reset_n) |->
    o_burst_start == 6'h21 && o_burst_end == 6'h1D && !o_widescreen_out_enable
    && !o_copy_data_out_enable) else $error("bad values after reset");
  a_color_rt_off: assert property (
    i_field_start && !i_realtime_control_enable |=> !o_color_detect_active)
    else $error("colour detect active without realtime enable");
  a_color_no_bit: assert property (
    i_field_start && !i_rt_color_detect |=> !o_color_detect_active)
    else $error("colour detect active without input bit");
  a_field_rt_off: assert property (
    i_field_start && !i_realtime_control_enable
    |=> o_field_sequence == $past(i_field_rate_select))
    else $error("field sequence not from register bit");
  a_field_agree: assert property (
    i_field_start && (i_rt_field_rate == i_field_rate_select)
    |=> o_field_sequence == $past(i_field_rate_select))
    else $error("field sequence wrong when sources agree");
  a_ack_width: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8])
    else $error("data line pull too short");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line changed while clock high");
  a_oe_bounded: assert property (o_sda_oe |-> ##[1:250] !o_sda_oe)
    else $error("data line held too long");
endmodule // evb_i2c_regs_monitor

// ===== testbench/evb_host_model.sv
`timescale 1ns/1ns
module evb_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  task hq;
    repeat (8) @(negedge i_ref_clk);
  endtask
  // start: data falls while clock high
  task start;
    o_sda_pull = 1'b0; o_scl = 1'b1; hq; o_sda_pull = 1'b1; hq; o_scl = 1'b0; hq;
  endtask
  // stop: data rises while clock high
  task stop;
    o_sda_pull = 1'b1; hq; o_scl = 1'b1; hq; o_sda_pull = 1'b0; hq;
  endtask
  task bit_io(input logic b, output logic r);
    o_sda_pull = ~b; hq; o_scl = 1'b1; hq; r = i_sda; o_scl = 1'b0; hq;
  endtask
  task send(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nack);
  endtask
  // master acks all but last read byte
  task recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(last, r);
  endtask
endmodule // evb_host_model

// ===== testbench/tb.sv
`timescale 1ns/1ns
module tb;
  logic clk = 0, rst_n = 0, fs = 0, rte = 0, frs = 0, rtf = 0, rtc = 0;
  logic scl, pull, oe, nack, wen, col, fseq, cen;
  logic [13:0] widescreen_code_bits;
  logic [5:0] bs, be;
  logic [19:0] cg;
  logic [7:0] rd;
  wire sda = ~(oe | pull);
  int err_count = 0, checks = 0;
  // check bits set in the copy byte msbs
  logic [7:0] wr_tab [7] = '{8'hA5, 8'hBF, 8'hD9, 8'h3F, 8'h5A, 8'h8B, 8'h8F};
  logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h21, 8'h1D, 8'h00, 8'h00, 8'h00};
  initial forever #10 clk = ~clk;
  evb_host_model i_host (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
  evb_i2c_regs i_dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_oe(oe), .i_field_start(fs), .i_realtime_control_enable(rte),
    .i_field_rate_select(frs), .i_rt_field_rate(rtf), .i_rt_color_detect(rtc),
    .o_widescreen_out_enable(wen), .o_widescreen_code_bits(widescreen_code_bits),
    .o_color_detect_active(col), .o_field_sequence(fseq), .o_burst_start(bs),
    .o_burst_end(be), .o_copy_data_out_enable(cen), .o_copy_gen_code(cg));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task end_sim;
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task put(input logic [7:0] d);
    i_host.send(d, nack);
    chk("ack", 0, nack);
  endtask
  task set_sub(input logic [6:0] a, input logic [7:0] s);
    i_host.start;
    put({a, 1'b0});
    put(s);
  endtask
  task read_all(input logic [6:0] a, input logic w);
    set_sub(a, 8'h26);
    i_host.stop;
    i_host.start;
    put({a, 1'b1});
    for (int i = 0; i < 7; i++) begin
      i_host.recv(i == 6, rd);
      chk("readback", w ? wr_tab[i] : rst_tab[i], rd);
    end
    i_host.stop;
  endtask
  task field;
    @(negedge clk) fs = 1;
    @(negedge clk) fs = 0;
    @(negedge clk);
  endtask
  task reset_dut;
    rst_n = 0;
    repeat (5) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    chk("burst start", 'h21, bs);
    chk("burst end", 'h1D, be);
    chk("wss enable", 0, wen);
    chk("copy enable", 0, cen);
  endtask
  initial begin
    reset_dut;
    read_all(7'h44, 0);
    set_sub(7'h46, 8'h26);
    for (int i = 0; i < 7; i++) put(wr_tab[i]);
    i_host.stop;
    chk("burst start held", 'h21, bs);
    field;
    chk("wss code", 'h3FA5, widescreen_code_bits);
    chk("wss enable", 1, wen);
    chk("burst start", 'h19, bs);
    chk("burst end", 'h3F, be);
    chk("copy code", 'hF8B5A, cg);
    chk("copy enable", 1, cen);
    read_all(7'h44, 1);
    i_host.start;
    i_host.send(8'h8A, nack);
    chk("foreign address", 1, nack);
    i_host.stop;
    for (int i = 0; i < 8; i++) begin
      rte = i[0]; frs = i[1]; rtc = i[2]; rtf = i[1] ^ i[2];
      field;
      chk("colour detect", {31'h0, rte & rtc}, col);
      chk("field seq", {31'h0, rte ? rtf : frs}, fseq);
    end
    // second reset in mid-run, with both enables and new values standing
    reset_dut;
    rte = 1; frs = 1; rtc = 1; rtf = 0;
    field;
    chk("colour detect off", 0, col);
    chk("field seq register", 1, fseq);
    read_all(7'h46, 0);
    set_sub(7'h44, 8'h2D);
    put(8'h5A);
    i_host.start;
    put({7'h44, 1'b1});
    i_host.recv(1, rd);
    chk("unmapped read", 0, rd);
    i_host.stop;
    end_sim;
  end
  initial begin
    #1_000_000;
    err_count++;
    end_sim;
  end
endmodule // tb
bind evb_i2c_regs evb_i2c_regs_monitor i_mon (.*);
